/* File: design/asp_pkg.sv */
// constants and types shared by the asynchronous serial port
`default_nettype none
package asp_pkg;
   // *********************************************************
   // framing
   // *********************************************************
   localparam int unsigned ASP_DATA_BITS     = 8;
   localparam logic [2:0]  ASP_DATA_LAST     = 3'h7;
   // *********************************************************
   // baud timer
   // *********************************************************
   localparam logic [7:0]  ASP_TIMER_MAX     = 8'hff;
   localparam logic [7:0]  ASP_TIMER_RESET   = 8'h00;
   localparam int unsigned ASP_NUM_DIV       = 3;
   // terminal counts of the system clock dividers: /4, /12, /48
   localparam logic [5:0]  ASP_DIV_LAST [ASP_NUM_DIV] = '{6'h03, 6'h0b, 6'h2f};
   localparam logic [5:0]  ASP_DIV_RESET     = 6'h00;
   localparam logic [2:0]  ASP_EXT_DIV_LAST  = 3'h7;
   localparam logic [2:0]  ASP_EXT_DIV_RESET = 3'h0;
   // *********************************************************
   // reset values
   // *********************************************************
   localparam logic [7:0]  ASP_RX_DATA_RESET = 8'h00;
   localparam logic [7:0]  ASP_SHIFT_RESET   = 8'h00;
   localparam logic [2:0]  ASP_BIT_CNT_RESET = 3'h0;
   // *********************************************************
   // pin synchroniser lanes
   // *********************************************************
   localparam int unsigned ASP_NUM_SYNC      = 3;
   localparam int unsigned ASP_SYNC_RX       = 0;
   localparam int unsigned ASP_SYNC_EXTOSC   = 1;
   localparam int unsigned ASP_SYNC_T1PIN    = 2;
   // *********************************************************
   // transmit buffer
   // *********************************************************
   localparam int unsigned ASP_TX_FIFO_WIDTH = 8;
   localparam int unsigned ASP_TX_FIFO_DEPTH = 4;
   // *********************************************************
   // types
   // *********************************************************
   typedef enum logic [2:0] {
      ASP_SRC_DIV12  = 3'b000,
      ASP_SRC_DIV4   = 3'b001,
      ASP_SRC_DIV48  = 3'b010,
      ASP_SRC_EXTOSC = 3'b011,
      ASP_SRC_T1PIN  = 3'b100,
      ASP_SRC_SYSTEM_CLOCK = 3'b101
   } asp_clk_src_e;
   typedef enum logic [2:0] {
      ASP_IDLE  = 3'b000,
      ASP_START = 3'b001,
      ASP_DATA  = 3'b010,
      ASP_NINTH = 3'b011,
      ASP_STOP  = 3'b100
   } asp_state_e;
endpackage : asp_pkg
`default_nettype wire

/* File: design/asp_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
`default_nettype none
module asp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire  logic             clock,
   input  wire  logic             rst,
   input  wire  logic             in_valid,
   output logic                   in_ready,
   input  wire  logic [WIDTH-1:0] in_data,
   output logic                   out_valid,
   input  wire  logic             out_ready,
   output logic       [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   // *********************************************************
   // storage and pointers
   // *********************************************************
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr];
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end
endmodule // asp_fifo
`default_nettype wire

/* File: design/asp_serial_port.sv */
// asynchronous serial port with baud timer, receive latch and transmit buffer
`default_nettype none
// Overview of operation
// (RQ1) full duplex; frame length select picks eight-bit or nine-bit framing
// (RQ2) shifter and receive latch are separate so a second byte can arrive
// (RQ3) buffer writes go to transmit, reads return the receive latch only
// (RQ4) done flags stay set until software clears them
// (RQ5) baud ticks from 8-bit auto-reload timer overflows divided by two
// (RQ6) private receive timer shares reload value, reloads on start edge
// (RQ7) software picks reload so overflows come at twice the bit rate
// (RQ8) timer clock: system clock /4, /12, /48, oscillator /8, or pin; the code also offers the undivided system clock (select 5)
// (RQ9) eight-bit frame: start, eight data bits lsb first, stop
// (RQ10) eight-bit mode: data to latch, stop bit to received ninth bit
// (RQ11) buffer write starts sending; tx done set at stop bit start
// (RQ12) reception only while receive enable bit is one
// (RQ13) eight-bit accept needs rx done clear, and stop one when filtering
// (RQ14) on overrun the first byte stays latched, the later one is lost
// (RQ15) rejected character leaves latch and ninth bit alone, no rx done
// (RQ16) nine-bit frame: start, eight data, programmable ninth bit, stop
// (RQ17) transmitted ninth bit is the software tx ninth bit
// (RQ18) nine-bit mode: received ninth bit stored, stop bit ignored
// (RQ19) nine-bit accept needs rx done clear, ninth one when filtering
// (RQ20) interrupt request when enabled and either done flag is set
// (RQ21) frame length select zero is eight-bit, one is nine-bit
// (RQ22) rx done is set at the stop bit sampling instant
// (RQ23) line idles high, start bit low, stop bit high
// (RQ24) receiver samples bit centres timed from the start edge reload
module asp_serial_port
   import asp_pkg::*;
(
   input  wire  logic       clock,
   input  wire  logic       rst,
   input  wire  logic       frame_length_select,
   input  wire  logic       multidrop_filter_enable,
   input  wire  logic       receive_enable_bit,
   input  wire  logic       tx_ninth_bit,
   output logic             rx_ninth_bit,
   output logic             tx_done_flag,
   output logic             rx_done_flag,
   input  wire  logic       tx_done_clear,
   input  wire  logic       rx_done_clear,
   input  wire  logic       buffer_write,
   input  wire  logic [7:0] buffer_write_data,
   output logic             buffer_write_ready,
   output logic       [7:0] serial_data_buffer,
   input  wire  logic       interrupt_enable,
   output logic             irq,
   input  wire  logic       timer_run,
   input  wire  logic [7:0] baud_reload_value,
   input  wire  logic [2:0] clock_source_select,
   input  wire  logic       ext_osc_clock,
   input  wire  logic       timer_ext_input,
   input  wire  logic       serial_in_pin,
   output logic             serial_out_pin
);
   // *********************************************************
   // pin synchronisers
   // *********************************************************
   logic [ASP_NUM_SYNC-1:0] sync1;
   logic [ASP_NUM_SYNC-1:0] sync2;
   logic [ASP_NUM_SYNC-1:0] sync3;
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1 <= '1;
         sync2 <= '1;
         sync3 <= '1;
      end else begin
         sync1 <= {timer_ext_input, ext_osc_clock, serial_in_pin};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   logic rx_line;
   logic rx_fall;
   logic osc_rise;
   logic pin_fall;
   assign rx_line  = sync2[ASP_SYNC_RX];
   assign rx_fall  = sync3[ASP_SYNC_RX] & ~sync2[ASP_SYNC_RX];
   assign osc_rise = ~sync3[ASP_SYNC_EXTOSC] & sync2[ASP_SYNC_EXTOSC];
   assign pin_fall = sync3[ASP_SYNC_T1PIN] & ~sync2[ASP_SYNC_T1PIN];
   // *********************************************************
   // timer clock source
   // *********************************************************
   logic [ASP_NUM_DIV-1:0] div_tick;
   genvar gi;
   generate
      for (gi = 0; gi < ASP_NUM_DIV; gi++) begin : g_div
         logic [5:0] div_cnt;
         assign div_tick[gi] = (div_cnt == ASP_DIV_LAST[gi]);
         always_ff @(posedge clock) begin
            if (rst) begin
               div_cnt <= ASP_DIV_RESET;
            end else if (div_tick[gi]) begin
               div_cnt <= ASP_DIV_RESET;
            end else begin
               div_cnt <= 6'(div_cnt + 1'b1);
            end
         end
      end
   endgenerate
   logic [2:0] osc_cnt;
   logic       osc_tick;
   assign osc_tick = osc_rise & (osc_cnt == ASP_EXT_DIV_LAST);
   always_ff @(posedge clock) begin
      if (rst) begin
         osc_cnt <= ASP_EXT_DIV_RESET;
      end else if (osc_rise) begin
         osc_cnt <= 3'(osc_cnt + 1'b1);
      end
   end
   logic t1_tick;
   always_comb begin
      case (asp_clk_src_e'(clock_source_select)) // RQ8
         ASP_SRC_DIV4:   t1_tick = div_tick[0];
         ASP_SRC_DIV12:  t1_tick = div_tick[1];
         ASP_SRC_DIV48:  t1_tick = div_tick[2];
         ASP_SRC_EXTOSC: t1_tick = osc_tick;
         ASP_SRC_T1PIN:  t1_tick = pin_fall;
         ASP_SRC_SYSTEM_CLOCK: t1_tick = 1'b1;
         default:        t1_tick = 1'b0;
      endcase
   end
   logic timer_step;
   assign timer_step = timer_run & t1_tick;
   // *********************************************************
   // transmit timer
   // *********************************************************
   logic [7:0] baud_timer_low;
   logic       tx_half;
   logic       tx_ovf;
   logic       tx_bit_tick;
   assign tx_ovf      = timer_step & (baud_timer_low == ASP_TIMER_MAX);
   assign tx_bit_tick = tx_ovf & tx_half; // RQ5
   always_ff @(posedge clock) begin
      if (rst) begin
         baud_timer_low <= ASP_TIMER_RESET;
         tx_half        <= 1'b0;
      end else if (timer_step) begin
         if (tx_ovf) begin
            baud_timer_low <= baud_reload_value; // RQ5
            tx_half        <= ~tx_half;
         end else begin
            baud_timer_low <= 8'(baud_timer_low + 1'b1);
         end
      end
   end
   // *********************************************************
   // receive timer
   // *********************************************************
   asp_state_e rx_state;
   logic [7:0] rx_timer;
   logic       rx_half;
   logic       rx_start_detect;
   logic       rx_ovf;
   logic       rx_sample;
   assign rx_start_detect = (rx_state == ASP_IDLE) & receive_enable_bit & rx_fall; // RQ12 RQ23
   assign rx_ovf          = timer_step & (rx_timer == ASP_TIMER_MAX);
   // first overflow after the start edge lands mid start bit
   assign rx_sample       = rx_ovf & ~rx_half & ~rx_start_detect & (rx_state != ASP_IDLE); // RQ24
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_timer <= ASP_TIMER_RESET;
         rx_half  <= 1'b0;
      end else if (rx_start_detect) begin
         rx_timer <= baud_reload_value; // RQ6
         rx_half  <= 1'b0;
      end else if (timer_step) begin
         if (rx_ovf) begin
            rx_timer <= baud_reload_value; // RQ6
            rx_half  <= ~rx_half; // RQ5
         end else begin
            rx_timer <= 8'(rx_timer + 1'b1);
         end
      end
   end
   // *********************************************************
   // receiver
   // *********************************************************
   logic [7:0] rx_shift;
   logic [2:0] rx_bit_cnt;
   logic       rx_ninth_capt;
   logic       rx_check_bit;
   logic       rx_accept;
   logic       rx_stop_sample;
   assign rx_stop_sample = rx_sample & (rx_state == ASP_STOP);
   // eight-bit mode checks the stop bit, nine-bit mode the ninth
   assign rx_check_bit   = frame_length_select ? rx_ninth_capt : rx_line; // RQ18 RQ21
   assign rx_accept      = rx_stop_sample & ~rx_done_flag & receive_enable_bit
                           & (~multidrop_filter_enable | rx_check_bit); // RQ13 RQ19 RQ14
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_state      <= ASP_IDLE;
         rx_shift      <= ASP_SHIFT_RESET;
         rx_bit_cnt    <= ASP_BIT_CNT_RESET;
         rx_ninth_capt <= 1'b0;
      end else if (!receive_enable_bit) begin
         rx_state <= ASP_IDLE; // RQ12
      end else if (rx_start_detect) begin
         rx_state <= ASP_START;
      end else if (rx_sample) begin
         case (rx_state)
            ASP_START: begin
               // a high level at mid start bit is a glitch
               rx_state   <= rx_line ? ASP_IDLE : ASP_DATA; // RQ23
               rx_bit_cnt <= ASP_BIT_CNT_RESET;
            end
            ASP_DATA: begin
               rx_shift   <= {rx_line, rx_shift[7:1]}; // RQ9 RQ16
               rx_bit_cnt <= 3'(rx_bit_cnt + 1'b1);
               if (rx_bit_cnt == ASP_DATA_LAST) begin
                  rx_state <= frame_length_select ? ASP_NINTH : ASP_STOP; // RQ1
               end
            end
            ASP_NINTH: begin
               rx_ninth_capt <= rx_line; // RQ16
               rx_state      <= ASP_STOP;
            end
            ASP_STOP: begin
               rx_state <= ASP_IDLE;
            end
            default: begin
               rx_state <= ASP_IDLE;
            end
         endcase
      end
   end
   // receive latch, separate from the shifter
   always_ff @(posedge clock) begin
      if (rst) begin
         serial_data_buffer <= ASP_RX_DATA_RESET;
         rx_ninth_bit       <= 1'b0;
      end else if (rx_accept) begin
         serial_data_buffer <= rx_shift; // RQ2 RQ3 RQ10 RQ15
         rx_ninth_bit       <= rx_check_bit; // RQ10 RQ18 RQ15
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_done_flag <= 1'b0;
      end else if (rx_accept) begin
         rx_done_flag <= 1'b1; // RQ22 RQ15
      end else if (rx_done_clear) begin
         rx_done_flag <= 1'b0; // RQ4
      end
   end
   // *********************************************************
   // transmit buffer
   // *********************************************************
   asp_state_e tx_state;
   logic       fifo_valid;
   logic       fifo_ready;
   logic [7:0] fifo_data;
   logic       tx_load;
   assign tx_load    = tx_bit_tick & ((tx_state == ASP_IDLE) | (tx_state == ASP_STOP));
   assign fifo_ready = tx_load;
   asp_fifo #(
      .WIDTH (ASP_TX_FIFO_WIDTH),
      .DEPTH (ASP_TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (buffer_write), // RQ3 RQ11
      .in_ready  (buffer_write_ready),
      .in_data   (buffer_write_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );
   // *********************************************************
   // transmitter
   // *********************************************************
   logic [7:0] tx_shift;
   logic [2:0] tx_bit_cnt;
   logic       tx_ninth;
   logic       tx_end;
   assign tx_end = tx_bit_tick & (((tx_state == ASP_DATA) & (tx_bit_cnt == ASP_DATA_LAST)
                   & ~frame_length_select) | (tx_state == ASP_NINTH));
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_state       <= ASP_IDLE;
         tx_shift       <= ASP_SHIFT_RESET;
         tx_bit_cnt     <= ASP_BIT_CNT_RESET;
         tx_ninth       <= 1'b0;
         serial_out_pin <= 1'b1;
      end else if (tx_bit_tick) begin
         case (tx_state)
            ASP_IDLE, ASP_STOP: begin
               if (fifo_valid) begin
                  tx_state       <= ASP_START; // RQ11
                  tx_shift       <= fifo_data;
                  tx_ninth       <= tx_ninth_bit; // RQ17
                  tx_bit_cnt     <= ASP_BIT_CNT_RESET;
                  serial_out_pin <= 1'b0; // RQ23
               end else begin
                  tx_state       <= ASP_IDLE;
                  serial_out_pin <= 1'b1; // RQ23
               end
            end
            ASP_START: begin
               tx_state       <= ASP_DATA;
               serial_out_pin <= tx_shift[0]; // RQ9 RQ16
               tx_shift       <= {1'b0, tx_shift[7:1]};
            end
            ASP_DATA: begin
               if (tx_bit_cnt == ASP_DATA_LAST) begin
                  if (frame_length_select) begin
                     tx_state       <= ASP_NINTH; // RQ1 RQ21
                     serial_out_pin <= tx_ninth; // RQ17
                  end else begin
                     tx_state       <= ASP_STOP;
                     serial_out_pin <= 1'b1; // RQ23
                  end
               end else begin
                  serial_out_pin <= tx_shift[0];
                  tx_shift       <= {1'b0, tx_shift[7:1]};
                  tx_bit_cnt     <= 3'(tx_bit_cnt + 1'b1);
               end
            end
            ASP_NINTH: begin
               tx_state       <= ASP_STOP;
               serial_out_pin <= 1'b1; // RQ23
            end
            default: begin
               tx_state       <= ASP_IDLE;
               serial_out_pin <= 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_done_flag <= 1'b0;
      end else if (tx_end) begin
         tx_done_flag <= 1'b1; // RQ11
      end else if (tx_done_clear) begin
         tx_done_flag <= 1'b0; // RQ4
      end
   end
   // *********************************************************
   // interrupt request
   // *********************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= interrupt_enable & (tx_done_flag | rx_done_flag); // RQ20
      end
   end
endmodule // asp_serial_port
`default_nettype wire

/* File: verif/asp_checker.sv */
// assertion checker for the asynchronous serial port
`default_nettype none
module asp_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       receive_enable_bit,
   input wire logic       rx_ninth_bit,
   input wire logic       tx_done_flag,
   input wire logic       rx_done_flag,
   input wire logic       tx_done_clear,
   input wire logic       rx_done_clear,
   input wire logic [7:0] serial_data_buffer,
   input wire logic       interrupt_enable,
   input wire logic       irq,
   input wire logic       timer_run,
   input wire logic [7:0] baud_reload_value,
   input wire logic [2:0] clock_source_select,
   input wire logic       serial_out_pin
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_tx_sticky;
      tx_done_flag && !tx_done_clear |=> tx_done_flag;
   endproperty
   a_tx_sticky: assert property (p_tx_sticky)
      else $error("tx done flag dropped without clear");
   property p_rx_sticky;
      rx_done_flag && !rx_done_clear |=> rx_done_flag;
   endproperty
   a_rx_sticky: assert property (p_rx_sticky)
      else $error("rx done flag dropped without clear");
   property p_latch_on_accept;
      !$stable({serial_data_buffer, rx_ninth_bit}) |-> $rose(rx_done_flag);
   endproperty
   a_latch_on_accept: assert property (p_latch_on_accept)
      else $error("receive latch changed without rx done rising");
   property p_overrun_keep;
      rx_done_flag && !rx_done_clear |=> $stable(serial_data_buffer);
   endproperty
   a_overrun_keep: assert property (p_overrun_keep)
      else $error("receive latch overwritten while rx done set");
   property p_rx_off;
      !receive_enable_bit && !rx_done_flag |=> !rx_done_flag;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("character accepted while reception disabled");
   property p_irq_on;
      interrupt_enable && (tx_done_flag || rx_done_flag) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("irq missing with a done flag set");
   property p_irq_off;
      !interrupt_enable |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq raised while disabled");
   property p_start_len;
      $fell(serial_out_pin) && timer_run && clock_source_select == 3'h5 && baud_reload_value == 8'hfc
         |-> (!serial_out_pin) [*8];
   endproperty
   a_start_len: assert property (p_start_len)
      else $error("start bit not one bit time low");
   property p_tx_done_stop;
      $rose(tx_done_flag) |-> serial_out_pin ##1 serial_out_pin;
   endproperty
   a_tx_done_stop: assert property (p_tx_done_stop)
      else $error("tx done not in stop bit time");
endmodule // asp_checker
bind asp_serial_port asp_checker u_chk (.clock, .rst, .receive_enable_bit, .rx_ninth_bit, .tx_done_flag,
   .rx_done_flag, .tx_done_clear, .rx_done_clear, .serial_data_buffer, .interrupt_enable, .irq, .timer_run,
   .baud_reload_value, .clock_source_select, .serial_out_pin);
`default_nettype wire

/* File: verif/asp_remote_node.sv */
// remote serial node model driving and watching the serial lines
`default_nettype none
module asp_remote_node (
   input  wire logic       clock,
   input  wire logic       line_in,
   input  wire logic [9:0] bit_cycles,
   output var  logic       line_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // frame send and capture
   // ****************************************
   initial line_out = 1'h1;
   task automatic send(input logic [7:0] d, input logic nine, input logic stop, input logic m9);
      logic [10:0] f;
      f = m9 ? {stop, nine, d, 1'h0} : {1'h1, stop, d, 1'h0};
      for (int i = 0; i < (m9 ? 11 : 10); i++) begin
         line_out <= f[i];
         repeat (bit_cycles) @(posedge clock);
      end
      line_out <= 1'h1;
   endtask
   // got is start, stop, ninth, data
   task automatic recv(input logic m9, output logic [10:0] got);
      logic [10:0] f;
      f = '1;
      @(posedge clock);
      while (line_in !== 1'h0) @(posedge clock);
      repeat (bit_cycles / 2) @(posedge clock);
      for (int i = 0; i < (m9 ? 11 : 10); i++) begin
         f[i] = line_in;
         if (i < (m9 ? 10 : 9)) repeat (bit_cycles) @(posedge clock);
      end
      got = m9 ? {f[0], f[10], f[9], f[8:1]} : {f[0], f[9], 1'h0, f[8:1]};
   endtask
endmodule // asp_remote_node
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking testbench for the asynchronous serial port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic clock, rst = 1'h1, frame_length_select = 1'h0, multidrop_filter_enable = 1'h0;
   logic receive_enable_bit = 1'h1, tx_ninth_bit = 1'h0, tx_done_clear = 1'h0, rx_done_clear = 1'h0;
   logic buffer_write = 1'h0, interrupt_enable = 1'h1, timer_run = 1'h1, ext_osc_clock = 1'h0;
   logic rx_ninth_bit, tx_done_flag, rx_done_flag, buffer_write_ready, irq;
   logic serial_in_pin, serial_out_pin;
   logic [7:0]  buffer_write_data = 8'h00, baud_reload_value = 8'hfc, serial_data_buffer;
   logic [2:0]  clock_source_select = 3'h5;
   logic [9:0]  bit_cycles = 10'h008;
   logic [10:0] got;
   logic [7:0]  acc[$];
   logic [10:0] rcv[$];
   logic [2:0]  src [6] = '{3'h5, 3'h1, 3'h0, 3'h2, 3'h3, 3'h4};
   logic [9:0]  bitc [6] = '{10'h008, 10'h020, 10'h060, 10'h180, 10'h080, 10'h010};
   // mode9, filter, clear, ninth, stop, data
   logic [12:0] rx_case [8] = '{13'h053c, 13'h01c3, 13'h0c5a, 13'h0d5a, 13'h0481, 13'h1de7, 13'h1ee7, 13'h1518};
   // rx done, rx ninth bit, latch
   logic [9:0]  rx_exp [8] = '{10'h33c, 10'h33c, 10'h13c, 10'h35a, 10'h281, 10'h081, 10'h3e7, 10'h218};
   int fails = 0, n_tests = 0, cycles = 0;
   asp_serial_port dut (.clock, .rst, .frame_length_select, .multidrop_filter_enable, .receive_enable_bit,
      .tx_ninth_bit, .rx_ninth_bit, .tx_done_flag, .rx_done_flag, .tx_done_clear, .rx_done_clear, .buffer_write,
      .buffer_write_data, .buffer_write_ready, .serial_data_buffer, .interrupt_enable, .irq, .timer_run,
      .baud_reload_value, .clock_source_select, .ext_osc_clock, .timer_ext_input(ext_osc_clock), .serial_in_pin,
      .serial_out_pin);
   asp_remote_node node (.clock, .line_in(serial_out_pin), .bit_cycles, .line_out(serial_in_pin));
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) ext_osc_clock <= ~ext_osc_clock;
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic end_test(input string name);
      $display("test %s finished, %0d mismatches so far", name, fails);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tx_frame(input logic [7:0] d, input logic m9, input logic nine);
      logic [10:0] g;
      frame_length_select <= m9;
      tx_ninth_bit <= nine;
      tx_done_clear <= 1'h1;
      buffer_write <= 1'h1;
      buffer_write_data <= d;
      fork
         begin
            @(posedge clock);
            buffer_write <= 1'h0;
            tx_done_clear <= 1'h0;
         end
         node.recv(m9, g);
      join
      chk(g, {1'h0, 1'h1, m9 & nine, d});
      chk({10'h000, tx_done_flag}, 11'h001);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      tick(3);
      rst <= 1'h0;
      @(posedge clock);
      chk({7'h00, serial_out_pin, tx_done_flag, rx_done_flag, buffer_write_ready}, 11'h009);
      chk({1'h0, irq, rx_ninth_bit, serial_data_buffer}, 11'h000);
      end_test("reset");
      for (int i = 0; i < 6; i++) begin
         clock_source_select <= src[i];
         bit_cycles <= bitc[i];
         @(posedge clock);
         tx_frame(8'ha5 ^ 8'(i), i[0], i[1]);
      end
      clock_source_select <= 3'h5;
      bit_cycles <= 10'h008;
      tick(2);
      chk({10'h000, irq}, 11'h001);
      tick(20);
      chk({10'h000, tx_done_flag}, 11'h001);
      interrupt_enable <= 1'h0;
      tx_done_clear <= 1'h1;
      tick(3);
      chk({9'h000, irq, tx_done_flag}, 11'h000);
      interrupt_enable <= 1'h1;
      tx_done_clear <= 1'h0;
      end_test("transmit");
      fork
         tx_frame(8'h96, 1'h0, 1'h0);
         node.send(8'h69, 1'h0, 1'h1, 1'h0);
      join
      tick(6);
      chk({1'h0, rx_done_flag, rx_ninth_bit, serial_data_buffer}, 11'h369);
      end_test("duplex");
      for (int i = 0; i < 8; i++) begin
         frame_length_select <= rx_case[i][12];
         multidrop_filter_enable <= rx_case[i][11];
         rx_done_clear <= rx_case[i][10];
         @(posedge clock);
         rx_done_clear <= 1'h0;
         node.send(rx_case[i][7:0], rx_case[i][9], rx_case[i][8], rx_case[i][12]);
         tick(6);
         chk({1'h0, rx_done_flag, rx_ninth_bit, serial_data_buffer}, {1'h0, rx_exp[i]});
      end
      receive_enable_bit <= 1'h0;
      rx_done_clear <= 1'h1;
      @(posedge clock);
      rx_done_clear <= 1'h0;
      node.send(8'h77, 1'h1, 1'h1, 1'h1);
      tick(6);
      chk({1'h0, rx_done_flag, rx_ninth_bit, serial_data_buffer}, 11'h018);
      receive_enable_bit <= 1'h1;
      frame_length_select <= 1'h0;
      end_test("receive");
      fork
         begin
            for (int i = 0; i < 6; i++) begin
               buffer_write <= 1'h1;
               buffer_write_data <= 8'h10 + 8'(i);
               @(posedge clock);
               if (buffer_write_ready === 1'h1) acc.push_back(buffer_write_data);
            end
            buffer_write <= 1'h0;
         end
         repeat (4) begin
            node.recv(1'h0, got);
            rcv.push_back(got);
         end
      join
      for (int j = 4; j < acc.size(); j++) begin
         node.recv(1'h0, got);
         rcv.push_back(got);
      end
      chk({9'h000, acc.size() >= 4, acc.size() < 6}, 11'h003);
      foreach (acc[k]) chk(rcv[k], {3'h2, acc[k]});
      tick(20);
      chk({10'h000, buffer_write_ready}, 11'h001);
      end_test("buffer");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
